//--- include/cca_regs.svh
// Register indices, field positions, reset values and counts of the counter array
`ifndef CCA_REGS_SVH
`define CCA_REGS_SVH
`define CCA_IX_CTRL 8'hd8
`define CCA_IX_MODE 8'hd9
`define CCA_IX_CPM0 8'hda
`define CCA_IX_CPM1 8'hdb
`define CCA_IX_CPM2 8'hdc
`define CCA_IX_CPL1 8'he9
`define CCA_IX_CPH1 8'hea
`define CCA_IX_CPL2 8'heb
`define CCA_IX_CPH2 8'hec
`define CCA_IX_CNTL 8'hf9
`define CCA_IX_CNTH 8'hfa
`define CCA_IX_CPL0 8'hfb
`define CCA_IX_CPH0 8'hfc
`define CCA_B_CF 7
`define CCA_B_CR 6
`define CCA_B_IDLE_SUSPEND 7
`define CCA_B_WATCHDOG_ENABLE 6
`define CCA_B_WATCHDOG_LOCK 5
`define CCA_B_WDF 2
`define CCA_B_ECF 0
`define CCA_B_PWM16 7
`define CCA_B_ECOM 6
`define CCA_B_CAPP 5
`define CCA_B_CAPN 4
`define CCA_B_MAT 3
`define CCA_B_TOG 2
`define CCA_B_PWM 1
`define CCA_B_ECCF 0
`define CCA_S_ECI 3
`define CCA_S_EXT 4
`define CCA_RST_MODE 8'h40
`define CCA_RST_BYTE 8'h00
`define CCA_DIV12_LAST 4'hb
`define CCA_DIV4_LAST 2'h3
`define CCA_EXT_LAST 3'h7
`define CCA_CNT_MAX 16'hffff
`define CCA_LO_MAX 8'hff
`define CCA_CNT_ONE 16'h0001
`endif

//--- include/cca_pkg.sv
// Types shared by the counter array design
package cca_pkg;
  typedef enum logic [2:0] {
    CCA_TB_DIV12, CCA_TB_DIV4, CCA_TB_T0, CCA_TB_ECI,
    CCA_TB_SYS, CCA_TB_EXT8, CCA_TB_RSV6, CCA_TB_RSV7
  } cca_tb_type;
endpackage

//--- src/cca_top.sv
// Counter array: 16-bit timebase counter, three capture/compare modules, watchdog
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "cca_regs.svh"
// Notes on behaviour
// - Counter wrapping from all ones to zero sets the overflow flag.
// - Overflow and module flags stay set until software writes them clear.
// - Run bit zero stops the counter, one lets it count.
// - Three unused control bits read zero; writes to them do nothing.
// - A module's match or capture sets that module's flag.
// - Interrupt request while overflow flag set and overflow enable is one.
// - Module flag with its module interrupt enable also raises the request.
// - Idle suspend bit halts the prescalers, counter and captures while the processor idles; bus writes still land.
// - Watchdog enable turns module 2 into the watchdog; set after reset.
// - Lock bit keeps the watchdog enabled until the next reset.
// - Timebase select picks /12, /4, timer 0, count input, clock, ext/8.
// - External oscillator divided by eight is synchronised before counting.
// - Mode register writes while the watchdog is enabled can only clear the enable bit, and only when unlocked.
// - Wide PWM bit selects 16-bit modulation, otherwise 8-bit.
// - Compare enable switches the module comparator on or off.
// - Rising or falling input edges capture the counter as enabled.
// - Match enable lets counter equal compare set the module flag.
// - Toggle enable inverts the module pin on each match.
// - Toggle plus modulation enable gives frequency output mode.
// - Modulation enable drives a PWM waveform, width by wide bit.
// - Counter and compares are 16 bits, reached as low and high bytes.
// - Compare low write clears compare enable; high write sets it.
// - Watchdog resets on low byte overflow while compare high equals count high.
// - Watchdog feed loads compare high with count high plus offset.
// - Counter runs regardless of run bit while the watchdog is enabled.
module cca_top
  import cca_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_idle,
  input wire logic i_timer0_ovf,
  input wire logic i_eci,
  input wire logic i_ext_osc,
  input wire logic [2:0] i_cex,
  output logic [2:0] o_cex,
  output logic o_irq,
  output logic o_wdt_reset
);
  localparam logic [7:0] CPM_IX [0:2] = '{`CCA_IX_CPM0, `CCA_IX_CPM1, `CCA_IX_CPM2};
  localparam logic [7:0] CPL_IX [0:2] = '{`CCA_IX_CPL0, `CCA_IX_CPL1, `CCA_IX_CPL2};
  localparam logic [7:0] CPH_IX [0:2] = '{`CCA_IX_CPH0, `CCA_IX_CPH1, `CCA_IX_CPH2};

  logic ack_reg;
  logic [7:0] rdat_reg;
  logic [7:0] rd_byte;
  logic bus_req;
  logic wr_go;
  logic [7:0] idx;
  logic [7:0] wd;

  logic [15:0] cnt_reg;
  logic cf_reg;
  logic cr_reg;
  logic [2:0] ccf_reg;
  logic idle_suspend_reg;
  logic watchdog_enable_reg;
  logic watchdog_lock_reg;
  cca_tb_type cps_reg;
  logic ecf_reg;
  logic [7:0] cpm_reg [0:2];
  logic [7:0] cpl_reg [0:2];
  logic [7:0] cph_reg [0:2];
  logic [2:0] cex_reg;
  logic wdt_rst_reg;

  logic [4:0] s1_reg;
  logic [4:0] s2_reg;
  logic [4:0] s3_reg;
  logic [4:0] pin_reg;
  logic [4:0] pin_next;
  logic [4:0] pin_rise;
  logic [4:0] pin_fall;
  logic [3:0] div12_reg;
  logic [1:0] div4_reg;
  logic [2:0] ext_reg;

  logic halt;
  logic act;
  logic tb_evt;
  logic tick;
  logic [15:0] cnt_inc;
  logic ovf;
  logic lo_ovf;
  logic [7:0] feed_val;
  logic [2:0] live;
  logic [2:0] hit8;
  logic [2:0] hit16;
  logic [2:0] short_cmp;
  logic [2:0] hit;
  logic [2:0] cap;
  logic [2:0] flag_set;

  function automatic logic wr_at(input logic [7:0] ix);
    return wr_go && (idx == ix);
  endfunction

  // Classic Wishbone slave, one byte per aligned word
  assign bus_req = i_wb_cyc & i_wb_stb;
  assign idx = i_wb_adr[9:2];
  assign wd = i_wb_dat[7:0];
  // Write lands on the edge the master sees ack
  assign wr_go = bus_req & ack_reg & i_wb_we & i_wb_sel[0] & i_ce;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_reg <= 1'b0;
      rdat_reg <= `CCA_RST_BYTE;
    end else if (i_ce) begin
      ack_reg <= bus_req & ~ack_reg;
      if (bus_req & ~ack_reg) begin
        rdat_reg <= rd_byte;
      end
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = {24'h00_0000, rdat_reg};

  always_comb begin
    rd_byte = `CCA_RST_BYTE;
    if (idx == `CCA_IX_CTRL) begin
      rd_byte = {cf_reg, cr_reg, 3'b000, ccf_reg};
    end else if (idx == `CCA_IX_MODE) begin
      rd_byte = {idle_suspend_reg, watchdog_enable_reg, watchdog_lock_reg, 1'b0, cps_reg, ecf_reg};
    end else if (idx == `CCA_IX_CNTL) begin
      rd_byte = cnt_reg[7:0];
    end else if (idx == `CCA_IX_CNTH) begin
      rd_byte = cnt_reg[15:8];
    end else if (idx == `CCA_IX_CPM0) begin
      rd_byte = cpm_reg[0];
    end else if (idx == `CCA_IX_CPM1) begin
      rd_byte = cpm_reg[1];
    end else if (idx == `CCA_IX_CPM2) begin
      rd_byte = cpm_reg[2];
    end else if (idx == `CCA_IX_CPL0) begin
      rd_byte = cpl_reg[0];
    end else if (idx == `CCA_IX_CPH0) begin
      rd_byte = cph_reg[0];
    end else if (idx == `CCA_IX_CPL1) begin
      rd_byte = cpl_reg[1];
    end else if (idx == `CCA_IX_CPH1) begin
      rd_byte = cph_reg[1];
    end else if (idx == `CCA_IX_CPL2) begin
      rd_byte = cpl_reg[2];
    end else if (idx == `CCA_IX_CPH2) begin
      rd_byte = cph_reg[2];
    end
  end

  // Pin synchronisers; a level counts once stages 2 and 3 agree
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_reg <= 5'h00;
      s2_reg <= 5'h00;
      s3_reg <= 5'h00;
      pin_reg <= 5'h00;
    end else if (i_ce) begin
      s1_reg <= {i_ext_osc, i_eci, i_cex};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      pin_reg <= pin_next;
    end
  end

  assign pin_next = (s3_reg & ~(s2_reg ^ s3_reg)) | (pin_reg & (s2_reg ^ s3_reg));
  assign pin_rise = pin_next & ~pin_reg;
  assign pin_fall = ~pin_next & pin_reg;

  assign halt = idle_suspend_reg & i_idle;
  assign act = i_ce & ~halt;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div12_reg <= 4'h0;
      div4_reg <= 2'h0;
      ext_reg <= 3'h0;
    end else if (act) begin
      div12_reg <= (div12_reg == `CCA_DIV12_LAST) ? 4'h0 : div12_reg + 4'h1;
      div4_reg <= div4_reg + 2'h1;
      if (pin_rise[`CCA_S_EXT]) begin
        ext_reg <= ext_reg + 3'h1;
      end
    end
  end

  always_comb begin
    case (cps_reg)
      CCA_TB_DIV12: tb_evt = (div12_reg == `CCA_DIV12_LAST);
      CCA_TB_DIV4: tb_evt = (div4_reg == `CCA_DIV4_LAST);
      CCA_TB_T0: tb_evt = i_timer0_ovf;
      CCA_TB_ECI: tb_evt = pin_fall[`CCA_S_ECI];
      CCA_TB_SYS: tb_evt = 1'b1;
      CCA_TB_EXT8: tb_evt = pin_rise[`CCA_S_EXT] && (ext_reg == `CCA_EXT_LAST);
      default: tb_evt = 1'b0;
    endcase
  end

  assign tick = act & (cr_reg | watchdog_enable_reg) & tb_evt;
  assign cnt_inc = cnt_reg + `CCA_CNT_ONE;
  assign ovf = tick & (cnt_reg == `CCA_CNT_MAX);
  assign lo_ovf = tick & (cnt_reg[7:0] == `CCA_LO_MAX);
  assign feed_val = cnt_reg[15:8] + cpl_reg[2];
  // Module 2 is taken over by the watchdog
  assign live = {~watchdog_enable_reg, 2'b11};

  always_comb begin
    for (int n = 0; n < 3; n++) begin
      hit8[n] = tick & cpm_reg[n][`CCA_B_ECOM] & (cnt_inc[7:0] == cpl_reg[n]);
      hit16[n] = tick & cpm_reg[n][`CCA_B_ECOM] & (cnt_inc == {cph_reg[n], cpl_reg[n]});
      short_cmp[n] = cpm_reg[n][`CCA_B_PWM]
        & (cpm_reg[n][`CCA_B_TOG] | ~cpm_reg[n][`CCA_B_PWM16]);
      hit[n] = short_cmp[n] ? hit8[n] : hit16[n];
      cap[n] = act & ((pin_rise[n] & cpm_reg[n][`CCA_B_CAPP])
        | (pin_fall[n] & cpm_reg[n][`CCA_B_CAPN]));
      flag_set[n] = live[n] & (cap[n] | (hit[n] & cpm_reg[n][`CCA_B_MAT]));
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_reg <= 16'h0000;
    end else if (wr_at(`CCA_IX_CNTL) && !watchdog_enable_reg) begin
      cnt_reg[7:0] <= wd;
    end else if (wr_at(`CCA_IX_CNTH) && !watchdog_enable_reg) begin
      cnt_reg[15:8] <= wd;
    end else if (tick) begin
      cnt_reg <= cnt_inc;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cf_reg <= 1'b0;
      cr_reg <= 1'b0;
      ccf_reg <= 3'b000;
    end else if (wr_at(`CCA_IX_CTRL)) begin
      cf_reg <= wd[`CCA_B_CF] | ovf;
      cr_reg <= wd[`CCA_B_CR];
      ccf_reg <= wd[2:0] | flag_set;
    end else begin
      cf_reg <= cf_reg | ovf;
      ccf_reg <= ccf_reg | flag_set;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      idle_suspend_reg <= 1'(`CCA_RST_MODE >> `CCA_B_IDLE_SUSPEND);
      watchdog_enable_reg <= 1'(`CCA_RST_MODE >> `CCA_B_WATCHDOG_ENABLE);
      watchdog_lock_reg <= 1'(`CCA_RST_MODE >> `CCA_B_WATCHDOG_LOCK);
      cps_reg <= CCA_TB_DIV12;
      ecf_reg <= 1'(`CCA_RST_MODE >> `CCA_B_ECF);
    end else if (wr_at(`CCA_IX_MODE)) begin
      if (!watchdog_enable_reg) begin
        idle_suspend_reg <= wd[`CCA_B_IDLE_SUSPEND];
        watchdog_enable_reg <= wd[`CCA_B_WATCHDOG_ENABLE] | wd[`CCA_B_WATCHDOG_LOCK];
        watchdog_lock_reg <= wd[`CCA_B_WATCHDOG_LOCK];
        cps_reg <= cca_tb_type'(wd[3:1]);
        ecf_reg <= wd[`CCA_B_ECF];
      end else if (!watchdog_lock_reg && !wd[`CCA_B_WATCHDOG_ENABLE]) begin
        watchdog_enable_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int n = 0; n < 3; n++) begin
        cpm_reg[n] <= `CCA_RST_BYTE;
      end
    end else begin
      for (int n = 0; n < 3; n++) begin
        if (wr_at(CPM_IX[n]) && live[n]) begin
          cpm_reg[n] <= wd;
        end else if (wr_at(CPL_IX[n])) begin
          cpm_reg[n][`CCA_B_ECOM] <= 1'b0;
        end else if (wr_at(CPH_IX[n])) begin
          cpm_reg[n][`CCA_B_ECOM] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int n = 0; n < 3; n++) begin
        cpl_reg[n] <= `CCA_RST_BYTE;
        cph_reg[n] <= `CCA_RST_BYTE;
      end
    end else begin
      for (int n = 0; n < 3; n++) begin
        if (wr_at(CPL_IX[n])) begin
          cpl_reg[n] <= wd;
        end else if (cap[n] && live[n]) begin
          cpl_reg[n] <= cnt_reg[7:0];
        end else if (live[n] && cpm_reg[n][`CCA_B_PWM] && cpm_reg[n][`CCA_B_TOG] && hit8[n]) begin
          cpl_reg[n] <= cpl_reg[n] + cph_reg[n];
        end else if (live[n] && short_cmp[n] && lo_ovf) begin
          // 8-bit duty reloads from the high byte
          cpl_reg[n] <= cph_reg[n];
        end
        if (wr_at(CPH_IX[n])) begin
          cph_reg[n] <= (n == 2 && watchdog_enable_reg) ? feed_val : wd;
        end else if (cap[n] && live[n]) begin
          cph_reg[n] <= cnt_reg[15:8];
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cex_reg <= 3'b000;
    end else begin
      for (int n = 0; n < 3; n++) begin
        if (!live[n]) begin
          cex_reg[n] <= cex_reg[n];
        end else if (cpm_reg[n][`CCA_B_PWM] && cpm_reg[n][`CCA_B_TOG]) begin
          if (hit8[n]) begin
            cex_reg[n] <= ~cex_reg[n];
          end
        end else if (cpm_reg[n][`CCA_B_PWM]) begin
          if (!cpm_reg[n][`CCA_B_ECOM]) begin
            cex_reg[n] <= 1'b0;
          end else if (hit[n]) begin
            cex_reg[n] <= 1'b1;
          end else if (cpm_reg[n][`CCA_B_PWM16] ? ovf : lo_ovf) begin
            cex_reg[n] <= 1'b0;
          end
        end else if (cpm_reg[n][`CCA_B_TOG] && hit16[n]) begin
          cex_reg[n] <= ~cex_reg[n];
        end
      end
    end
  end

  assign o_cex = cex_reg;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wdt_rst_reg <= 1'b0;
    end else if (i_ce) begin
      wdt_rst_reg <= watchdog_enable_reg & ((lo_ovf & (cph_reg[2] == cnt_reg[15:8]))
        | (wr_at(`CCA_IX_CTRL) & wd[`CCA_B_WDF]));
    end
  end

  assign o_wdt_reset = wdt_rst_reg;

  assign o_irq = (cf_reg & ecf_reg)
    | (|(ccf_reg & {cpm_reg[2][`CCA_B_ECCF], cpm_reg[1][`CCA_B_ECCF], cpm_reg[0][`CCA_B_ECCF]}));

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_feed;
    watchdog_enable_reg && wr_at(`CCA_IX_CPH2);
  endsequence

  sequence s_cpl0_wr;
    wr_at(`CCA_IX_CPL0) && !wr_at(CPM_IX[0]);
  endsequence

  AST_OVF_SETS_FLAG: assert property (ovf |=> cf_reg)
    else $error("overflow did not set flag");
  AST_FLAG_STICKY: assert property (cf_reg && !wr_at(`CCA_IX_CTRL) |=> cf_reg)
    else $error("overflow flag dropped by hardware");
  AST_STOPPED_HOLDS: assert property (!cr_reg && !watchdog_enable_reg && !wr_go |=> $stable(cnt_reg))
    else $error("stopped counter moved");
  AST_RSVD_ZERO: assert property (o_wb_ack && !i_wb_we && idx == `CCA_IX_CTRL
    |-> o_wb_dat[5:3] == 3'b000)
    else $error("unused control bits not zero");
  AST_IRQ_OVF: assert property (cf_reg && ecf_reg |-> o_irq)
    else $error("overflow request missing");
  AST_LOCK_HOLDS: assert property (watchdog_lock_reg |=> watchdog_enable_reg && watchdog_lock_reg)
    else $error("locked watchdog disabled");
  AST_MODE_FROZEN: assert property (watchdog_enable_reg |=> $stable(cps_reg) && $stable(idle_suspend_reg))
    else $error("mode changed under watchdog");
  AST_CPL_CLEARS_ECOM: assert property (s_cpl0_wr |=> !cpm_reg[0][`CCA_B_ECOM])
    else $error("low byte write kept compare enable");
  AST_WDT_FIRES: assert property (watchdog_enable_reg && lo_ovf && cph_reg[2] == cnt_reg[15:8]
    |=> o_wdt_reset ##1 !o_wdt_reset || watchdog_enable_reg)
    else $error("watchdog reset missing");
  AST_FEED_LOADS: assert property (s_feed |=> cph_reg[2] == $past(feed_val))
    else $error("watchdog feed value wrong");
  AST_WDT_RUNS: assert property (watchdog_enable_reg && tb_evt && act && !wr_go
    |=> cnt_reg == $past(cnt_inc))
    else $error("counter not running under watchdog");
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the counter array block
`timescale 1ns/10ps
`default_nettype none
`include "cca_regs.svh"
module testbench
  import cca_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [9:0] i_wb_adr = 10'h000;
  logic [31:0] i_wb_dat = 32'h0000_0000;
  logic [3:0] i_wb_sel = 4'h1;
  logic i_idle = 1'b0;
  logic i_timer0_ovf = 1'b0;
  logic i_eci = 1'b1;
  logic i_ext_osc = 1'b0;
  logic [2:0] i_cex = 3'h0;
  logic [31:0] o_wb_dat;
  logic o_wb_ack;
  logic o_irq;
  logic o_wdt_reset;
  logic [2:0] o_cex;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int t0;
  int n;
  int hi_cnt;
  logic [7:0] a;
  logic [7:0] b;
  logic [15:0] v;

  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) cycles <= cycles + 1;

  cca_top cca_top_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'b1),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_idle(i_idle), .i_timer0_ovf(i_timer0_ovf), .i_eci(i_eci), .i_ext_osc(i_ext_osc),
    .i_cex(i_cex), .o_cex(o_cex), .o_irq(o_irq), .o_wdt_reset(o_wdt_reset));

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_range(input string name, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("Error %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask

  // One classic cycle; waits for ack, takes data at that edge
  task automatic wb(input logic we, input logic [7:0] ix, input logic [7:0] d,
                    output logic [7:0] q);
    int k;
    k = 0;
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= {ix, 2'b00};
    i_wb_dat <= {24'h00_0000, d};
    do begin
      @(posedge i_clk);
      k++;
    end while (o_wb_ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      $display("Error bus ack expected 1 seen %b", o_wb_ack);
    end
    q = o_wb_dat[7:0];
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    logic [7:0] t;
    wb(1'b1, ix, d, t);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] ix, input logic [7:0] e);
    logic [7:0] t;
    wb(1'b0, ix, 8'h00, t);
    check(name, {8'h00, e}, {8'h00, t});
  endtask

  task automatic rd(input logic [7:0] ix, output logic [7:0] q);
    wb(1'b0, ix, 8'h00, q);
  endtask

  task automatic do_reset;
    i_rstn <= 1'b0;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
  endtask

  task automatic wait_pulse(input int lim, output int k);
    k = 0;
    while (o_wdt_reset !== 1'b1 && k < lim) begin
      @(posedge i_clk);
      k++;
    end
  endtask

  function automatic int tb_div(input cca_tb_type c);
    return (c == CCA_TB_DIV12) ? 12 : (c == CCA_TB_DIV4) ? 4 : 1;
  endfunction

  // Slack for free-running prescalers and bus turnaround
  function automatic int tb_tol(input cca_tb_type c);
    return (c == CCA_TB_DIV12 || c == CCA_TB_DIV4 || c == CCA_TB_SYS) ? 12 / tb_div(c) + 1 : 0;
  endfunction

  function automatic int tb_events(input cca_tb_type c, input int k);
    return (c == CCA_TB_RSV6 || c == CCA_TB_RSV7) ? 0 : k;
  endfunction

  task automatic gen(input cca_tb_type c, input int k);
    case (c)
      CCA_TB_T0: repeat (k) begin
        i_timer0_ovf <= 1'b1;
        @(posedge i_clk);
        i_timer0_ovf <= 1'b0;
        repeat (2) @(posedge i_clk);
      end
      CCA_TB_ECI: repeat (k) begin
        i_eci <= 1'b0;
        repeat (4) @(posedge i_clk);
        i_eci <= 1'b1;
        repeat (4) @(posedge i_clk);
      end
      CCA_TB_EXT8: repeat (8 * k) begin
        i_ext_osc <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_ext_osc <= 1'b0;
        repeat (2) @(posedge i_clk);
      end
      default: repeat (k * tb_div(c)) @(posedge i_clk);
    endcase
  endtask

  task automatic cap_chk(input logic lvl, input logic [7:0] e);
    i_cex[2] <= lvl;
    repeat (8) @(posedge i_clk);
    rd_chk("capture flags", `CCA_IX_CTRL, e);
    wr(`CCA_IX_CTRL, 8'h00);
  endtask

  initial begin
    repeat (60000) @(posedge i_clk);
    n_errors++;
    $display("Error run time expected finish seen timeout");
    stop_test;
  end

  initial begin
    void'($urandom(32'h0c02_90bc));
    do_reset;
    t0 = cycles;
    rd_chk("control reset", `CCA_IX_CTRL, 8'h00);
    rd_chk("mode reset", `CCA_IX_MODE, `CCA_RST_MODE);
    foreach (a[i]) rd_chk("byte reset", 8'hda + 8'(i % 3), `CCA_RST_BYTE);
    rd_chk("unmapped read", 8'h00, 8'h00);
    rd(`CCA_IX_CNTL, a);
    repeat (30) @(posedge i_clk);
    rd(`CCA_IX_CNTL, b);
    check("counter forced on", 16'h0001, {15'h0000, a !== b});
    wr(`CCA_IX_MODE, 8'h49);
    rd_chk("mode frozen", `CCA_IX_MODE, `CCA_RST_MODE);
    wait_pulse(4000, n);
    check_range("watchdog timeout", 256 * 12 - 90, 256 * 12 + 40, cycles - t0);
    wr(`CCA_IX_CTRL, 8'h04);
    wait_pulse(4, n);
    check("forced reset", 16'h0001, {15'h0000, o_wdt_reset});
    wr(`CCA_IX_MODE, 8'h00);
    rd_chk("watchdog off", `CCA_IX_MODE, 8'h00);
    wr(`CCA_IX_MODE, 8'h20);
    rd_chk("lock sets enable", `CCA_IX_MODE, 8'h60);
    wr(`CCA_IX_MODE, 8'h00);
    rd_chk("locked enable", `CCA_IX_MODE, 8'h60);
    do_reset;
    wr(`CCA_IX_MODE, 8'h00);
    wr(`CCA_IX_CTRL, 8'h38);
    rd_chk("unused bits", `CCA_IX_CTRL, 8'h00);
    v = 16'($urandom());
    wr(`CCA_IX_CNTL, v[7:0]);
    wr(`CCA_IX_CNTH, v[15:8]);
    repeat (20) @(posedge i_clk);
    rd_chk("count low", `CCA_IX_CNTL, v[7:0]);
    rd_chk("count high", `CCA_IX_CNTH, v[15:8]);
    for (int c = 0; c < 8; c++) begin
      n = 3 + int'($urandom_range(7));
      v = {8'($urandom_range(254)), 8'hfe};
      wr(`CCA_IX_MODE, {4'h0, 3'(c), 1'b0});
      wr(`CCA_IX_CNTL, v[7:0]);
      wr(`CCA_IX_CNTH, v[15:8]);
      wr(`CCA_IX_CTRL, 8'h40);
      gen(cca_tb_type'(c), n);
      repeat (8) @(posedge i_clk);
      wr(`CCA_IX_CTRL, 8'h00);
      rd(`CCA_IX_CNTL, a);
      rd(`CCA_IX_CNTH, b);
      check_range("timebase count", tb_events(cca_tb_type'(c), n),
        tb_events(cca_tb_type'(c), n) + tb_tol(cca_tb_type'(c)), int'({b, a} - v));
    end
    wr(`CCA_IX_MODE, 8'h09);
    wr(`CCA_IX_CNTL, 8'hf0);
    wr(`CCA_IX_CNTH, 8'hff);
    wr(`CCA_IX_CTRL, 8'h40);
    repeat (40) @(posedge i_clk);
    rd_chk("overflow flag", `CCA_IX_CTRL, 8'hc0);
    check("overflow irq", 16'h0001, {15'h0000, o_irq});
    repeat (50) @(posedge i_clk);
    rd_chk("flag held", `CCA_IX_CTRL, 8'hc0);
    wr(`CCA_IX_MODE, 8'h08);
    @(posedge i_clk);
    check("irq masked", 16'h0000, {15'h0000, o_irq});
    wr(`CCA_IX_CTRL, 8'h00);
    rd_chk("flag cleared", `CCA_IX_CTRL, 8'h00);
    wr(`CCA_IX_CNTL, 8'h00);
    wr(`CCA_IX_CNTH, 8'h00);
    v = 16'(32 + $urandom_range(190));
    wr(`CCA_IX_CPM0, 8'h49);
    wr(`CCA_IX_CPL0, v[7:0]);
    rd_chk("low write clears enable", `CCA_IX_CPM0, 8'h09);
    wr(`CCA_IX_CPH0, v[15:8]);
    rd_chk("high write sets enable", `CCA_IX_CPM0, 8'h49);
    wr(`CCA_IX_CPL1, v[7:0]);
    wr(`CCA_IX_CPH1, v[15:8]);
    wr(`CCA_IX_CPM1, 8'h44);
    wr(`CCA_IX_CPL2, v[7:0]);
    wr(`CCA_IX_CPH2, v[15:8]);
    wr(`CCA_IX_CPM2, 8'h08);
    wr(`CCA_IX_CTRL, 8'h40);
    repeat (300) @(posedge i_clk);
    rd_chk("match flags", `CCA_IX_CTRL, 8'h41);
    check("toggle pin", 16'h0002, {13'h0000, o_cex});
    check("module irq", 16'h0001, {15'h0000, o_irq});
    wr(`CCA_IX_CPM0, 8'h48);
    @(posedge i_clk);
    check("module irq masked", 16'h0000, {15'h0000, o_irq});
    // Duty comes from the high byte, reloaded at each low overflow
    wr(`CCA_IX_CPH1, v[7:0]);
    wr(`CCA_IX_CPM1, 8'h42);
    // One full period so the pin leaves its toggled level
    repeat (256) @(posedge i_clk);
    hi_cnt = 0;
    repeat (512) begin
      @(posedge i_clk);
      hi_cnt += int'(o_cex[1] === 1'b1);
    end
    check_range("pwm high time", 2 * (256 - v) - 8, 2 * (256 - v) + 8, hi_cnt);
    wr(`CCA_IX_CTRL, 8'h00);
    wr(`CCA_IX_CPM2, 8'h20);
    cap_chk(1'b1, 8'h04);
    cap_chk(1'b0, 8'h00);
    wr(`CCA_IX_CPM2, 8'h10);
    cap_chk(1'b1, 8'h00);
    cap_chk(1'b0, 8'h04);
    wr(`CCA_IX_MODE, 8'h88);
    wr(`CCA_IX_CTRL, 8'h40);
    i_idle <= 1'b1;
    rd(`CCA_IX_CNTL, a);
    repeat (30) @(posedge i_clk);
    rd_chk("idle halt", `CCA_IX_CNTL, a);
    i_idle <= 1'b0;
    repeat (30) @(posedge i_clk);
    rd(`CCA_IX_CNTL, b);
    check("idle resume", 16'h0001, {15'h0000, a !== b});
    stop_test;
  end
endmodule
`default_nettype wire
